// [hw/bucket_pkg.sv]
// Constants for the configuration-3 leaky-bucket activity monitor
package bucket_pkg;
  // Register offsets
  localparam logic [7:0] BUCKET_MAX_OFFSET  = 8'h5E;
  localparam logic [7:0] CLEAR_LEVEL_OFFSET = 8'h5D;
  localparam logic [7:0] DECAY_RATE_OFFSET  = 8'h5F;
  // Reset values
  localparam logic [7:0] BUCKET_MAX_RESET   = 8'h08;
  localparam logic [7:0] CLEAR_LEVEL_RESET  = 8'h04;
  localparam logic [1:0] DECAY_RATE_RESET   = 2'h1;
  // Decay field position
  localparam int         DECAY_MSB          = 1;
  // Monitoring cycle
  localparam int         CLK_MHZ            = 250;
  localparam int         CYCLE_MS           = 128;
  localparam longint     CYCLE_CLKS         = longint'(CYCLE_MS) * 1000 * 1000 * CLK_MHZ / 1000;
endpackage

// [hw/leaky_bucket_monitor.sv]
// Leaky-bucket activity monitor, configuration 3
//
// What this block does
// - Each monitoring cycle with a fault raises the accumulator by one.
// - Each 1, 2, 4 or 8 fault-free cycles lowers the accumulator by one.
// - Alarm clears when the accumulator falls to the lower threshold register.
// - Accumulator saturates at the bucket size register; a size written below it is clipped to it one clock after the write.
// - Bucket size register resets to 0x08 and is readable and writable.
`timescale 1ns/1ps
module leaky_bucket_monitor #(
  parameter longint CYCLE_CLKS = bucket_pkg::CYCLE_CLKS
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       fault_in,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] level_out,
  output logic            alarm_out,
  output logic            cycle_tick
);
  // ==========================================================
  // Registers
  logic [7:0] bucket_max_reg, bucket_max_next;
  logic [7:0] clear_level_reg, clear_level_next;
  logic [1:0] decay_reg, decay_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    bucket_max_next  = bucket_max_reg;
    clear_level_next = clear_level_reg;
    decay_next       = decay_reg;
    rdata_next       = rdata_reg;
    if (reg_wr) begin
      case (reg_addr)
        bucket_pkg::BUCKET_MAX_OFFSET:  bucket_max_next = reg_wdata;
        bucket_pkg::CLEAR_LEVEL_OFFSET: clear_level_next = reg_wdata;
        bucket_pkg::DECAY_RATE_OFFSET:  decay_next = reg_wdata[bucket_pkg::DECAY_MSB:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        bucket_pkg::BUCKET_MAX_OFFSET:  rdata_next = bucket_max_reg;
        bucket_pkg::CLEAR_LEVEL_OFFSET: rdata_next = clear_level_reg;
        bucket_pkg::DECAY_RATE_OFFSET:  rdata_next = {6'h00, decay_reg};
        default:                        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bucket_max_reg  <= bucket_pkg::BUCKET_MAX_RESET;
      clear_level_reg <= bucket_pkg::CLEAR_LEVEL_RESET;
      decay_reg       <= bucket_pkg::DECAY_RATE_RESET;
      rdata_reg       <= 8'h00;
    end else begin
      bucket_max_reg  <= bucket_max_next;
      clear_level_reg <= clear_level_next;
      decay_reg       <= decay_next;
      rdata_reg       <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Monitoring cycle divider; a fault seen anywhere in a cycle counts for it
  logic [31:0] div_reg, div_next;
  logic        seen_reg, seen_next;
  logic        tick_reg, tick_next;
  logic        end_cyc;

  always_comb begin
    end_cyc   = (div_reg == 32'(CYCLE_CLKS - 1));
    div_next  = end_cyc ? 32'h0 : div_reg + 32'h1;
    seen_next = end_cyc ? 1'b0 : (seen_reg | fault_in);
    tick_next = end_cyc;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg  <= 32'h0;
      seen_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      seen_reg <= seen_next;
      tick_reg <= tick_next;
    end
  end
  assign cycle_tick = tick_reg;

  // ==========================================================
  // Accumulator, decay counter and alarm
  logic [7:0] acc_reg, acc_next;
  logic [3:0] quiet_reg, quiet_next;
  logic       alarm_reg, alarm_next;
  logic       faulty;
  logic [3:0] period;

  always_comb begin
    faulty     = seen_reg | fault_in;
    period     = 4'(4'h1 << decay_reg);
    acc_next   = acc_reg;
    quiet_next = quiet_reg;
    alarm_next = alarm_reg;
    if (end_cyc) begin
      if (faulty) begin
        quiet_next = 4'h0;
        if (acc_reg < bucket_max_reg) begin
          acc_next = acc_reg + 8'h1;
        end
        if (acc_reg >= clear_level_reg && acc_reg != 8'h00) begin
          alarm_next = 1'b1;
        end
      end else if (quiet_reg + 4'h1 >= period) begin
        quiet_next = 4'h0;
        if (acc_reg != 8'h00) begin
          acc_next = acc_reg - 8'h1;
          if (acc_reg - 8'h1 <= clear_level_reg) begin
            alarm_next = 1'b0;
          end
        end
      end else begin
        quiet_next = quiet_reg + 4'h1;
      end
    end
    // Clip last, so a size written below the level wins over a same-cycle fall;
    // a clipped level at or below the clear level must also drop the alarm
    if (acc_reg > bucket_max_reg) begin
      acc_next = bucket_max_reg;
      if (bucket_max_reg <= clear_level_reg) begin
        alarm_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg   <= 8'h00;
      quiet_reg <= 4'h0;
      alarm_reg <= 1'b0;
    end else begin
      acc_reg   <= acc_next;
      quiet_reg <= quiet_next;
      alarm_reg <= alarm_next;
    end
  end
  assign level_out = acc_reg;
  assign alarm_out = alarm_reg;

  // ==========================================================
  // Checks
  rise_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    (end_cyc && faulty && acc_reg < bucket_max_reg)
    |=> acc_reg == $past(acc_reg) + 8'h1) else $error("accumulator did not rise");

  fall_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    (end_cyc && !faulty && quiet_reg + 4'h1 >= period && acc_reg != 8'h00
     && acc_reg <= bucket_max_reg)
    |=> acc_reg == $past(acc_reg) - 8'h1) else $error("accumulator did not fall");

  hold_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!end_cyc && acc_reg <= bucket_max_reg && !$changed(bucket_max_reg))
    |=> $stable(acc_reg)) else $error("accumulator moved between cycles");

  alarm_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($fell(acc_reg != 8'h00) || ($changed(acc_reg) && acc_reg < $past(acc_reg)
     && acc_reg <= clear_level_reg)) |-> !alarm_reg) else $error("alarm not cleared");

  // A size write may land below the level; the clip check below covers that cycle
  cap_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    (acc_reg <= bucket_max_reg && !(reg_wr && reg_addr == bucket_pkg::BUCKET_MAX_OFFSET))
    |=> acc_reg <= bucket_max_reg) else $error("bucket overflow");

  clip_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    (acc_reg > bucket_max_reg)
    |=> acc_reg == $past(bucket_max_reg)) else $error("level not clipped");

  zero_floor_a: assert property (@(posedge clk) disable iff (!rst_b)
    (end_cyc && !faulty && acc_reg == 8'h00)
    |=> acc_reg == 8'h00) else $error("level fell below zero");

  alarm_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (end_cyc && faulty && acc_reg >= clear_level_reg && acc_reg != 8'h00
     && acc_reg <= bucket_max_reg)
    |=> alarm_reg) else $error("alarm not raised");

  size_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == bucket_pkg::BUCKET_MAX_OFFSET)
    |=> bucket_max_reg == $past(reg_wdata)) else $error("size write lost");

  // A read in the cycle of a write returns the old value
  read_back_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == bucket_pkg::BUCKET_MAX_OFFSET)
    |=> reg_rdata == $past(bucket_max_reg)) else $error("size read wrong");

  clear_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == bucket_pkg::CLEAR_LEVEL_OFFSET)
    |=> clear_level_reg == $past(reg_wdata)) else $error("clear level write lost");

  decay_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == bucket_pkg::DECAY_RATE_OFFSET)
    |=> decay_reg == $past(reg_wdata[1:0])) else $error("decay write lost");

  // The divider must wrap exactly at the cycle length, never run past it
  div_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    div_reg <= 32'(CYCLE_CLKS - 1)) else $error("divider out of range");

  tick_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    end_cyc |=> (tick_reg && !seen_reg)) else $error("cycle end not marked");

  tick_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    tick_reg |=> !tick_reg) else $error("cycle tick too long");
endmodule

// [sim/leaky_bucket_activity_cfg3_test.sv]
// Self-checking bench for the configuration-3 leaky-bucket monitor
`timescale 1ns/1ps
module leaky_bucket_activity_cfg3_test;
  logic       clk;
  logic       rst_b;
  logic       fault_in;
  logic       reg_wr;
  logic       reg_rd;
  logic       rd_d = 1'b0;
  logic       alm = 1'b0;
  logic       cycle_tick;
  logic       alarm_out;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] level_out;
  logic [7:0] rq[$];
  logic [8:0] lq[$];
  int         err_count = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         lvl = 0;
  int         dcnt = 0;
  int         sz;
  int         clr;
  int         per;

  leaky_bucket_monitor #(.CYCLE_CLKS(8)) leaky_bucket_monitor_i (.clk(clk), .rst_b(rst_b),
    .fault_in(fault_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .level_out(level_out),
    .alarm_out(alarm_out), .cycle_tick(cycle_tick));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Output watcher; ticks before the model starts are skipped
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
  end

  // Outputs are looked at half a cycle after the edge that launches them
  always @(negedge clk) begin
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
    if (rd_d && rq.size() > 0)
      check("rdata", {1'b0, reg_rdata}, {1'b0, rq.pop_front()});
    if (cycle_tick && lq.size() > 0)
      check("level", {alarm_out, level_out}, lq.pop_front());
  end

  // ==========================================================
  // Drivers; a lowered strobe gets an idle cycle before reuse
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    rq.push_back(v);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
  endtask

  // Fault level is held to the cycle end; the next level is set before the next edge
  task automatic cycle(input logic f);
    fault_in = f;
    if (f) begin
      if (lvl >= clr && lvl != 0) alm = 1'b1;
      lvl = (lvl < sz) ? lvl + 1 : sz;
      dcnt = 0;
    end else if (++dcnt == per) begin
      dcnt = 0;
      lvl = (lvl > 0) ? lvl - 1 : 0;
      if (lvl <= clr) alm = 1'b0;
    end
    lq.push_back({alm, 8'(lvl)});
    @(negedge clk);
    while (!cycle_tick) @(negedge clk);
  endtask

  initial begin
    {rst_b, fault_in, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    void'($urandom(32'h8D85));
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd(bucket_pkg::BUCKET_MAX_OFFSET, 8'h08);
    rd(bucket_pkg::CLEAR_LEVEL_OFFSET, bucket_pkg::CLEAR_LEVEL_RESET);
    rd(8'h80, 8'h00);
    wr(bucket_pkg::BUCKET_MAX_OFFSET, 8'h03);
    wr(bucket_pkg::CLEAR_LEVEL_OFFSET, 8'h01);
    rd(bucket_pkg::BUCKET_MAX_OFFSET, 8'h03);
    sz = 3;
    clr = 1;
    while (!cycle_tick) @(negedge clk);
    @(negedge clk);
    for (int d = 0; d < 4; d++) begin
      wr(bucket_pkg::DECAY_RATE_OFFSET, 8'(d));
      rd(bucket_pkg::DECAY_RATE_OFFSET, 8'(d));
      per = 1 << d;
      repeat (5) cycle(1'b1);
      repeat (4 * per) cycle(1'b0);
    end
    repeat (40) cycle(1'($urandom % 2));
    fault_in = 1'b0;
    @(negedge clk);
    end_sim();
  end
endmodule
